// File: rtl/apc_params.svh
/*
 Constants for the converter control block: register indices, field
 positions, reset values and conversion timing.
 Assumes it is included by bare name after the package.
*/
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH
// Register indices; byte address is four times the index
`define APC_IDX_PCFG 10'h0ae
`define APC_IDX_MODE 10'h0b1
`define APC_IDX_RESH 10'h0b2
`define APC_IDX_RESL 10'h0b3
`define APC_IDX_IRQS 10'h0c0
`define APC_IDX_IRQM 10'h0c1
// Mode register fields
`define APC_MODE_EN 7
`define APC_MODE_START 6
`define APC_MODE_EOC 5
`define APC_MODE_CHEN 4
// Resolution and clock register fields
`define APC_RESL_CKS2 7
`define APC_RESL_CKS1 6
`define APC_RESL_LEN 5
`define APC_RESL_CKS0 4
// Interrupt status bits
`define APC_IRQ_DONE 0
`define APC_IRQ_REFUSED 1
// Reset values
`define APC_PCFG_RST 8'h00
`define APC_CHSEL_RST 3'h0
`define APC_CKS_RST 3'h0
`define APC_RES_RST 12'h000
`define APC_IRQ_RST 2'h0
// Conversion steps, each four converter clocks long
`define APC_STEPS12 7'd16
`define APC_STEPS8 7'd12
`define APC_PHASES 7'd4
`define APC_TICKS12 (`APC_STEPS12 * `APC_PHASES)
`define APC_TICKS8 (`APC_STEPS8 * `APC_PHASES)
// Converter clock divide ratios per select code
`define APC_DIV_0 7'd16
`define APC_DIV_1 7'd8
`define APC_DIV_2 7'd1
`define APC_DIV_3 7'd2
`define APC_DIV_4 7'd64
`define APC_DIV_5 7'd32
`define APC_DIV_6 7'd4
`define APC_DIV_7 7'd1
`endif

// File: rtl/apc_pkg.sv
/*
 Types of the converter control block.
 Assumes nothing of its surroundings.
*/
package apc_pkg;
   typedef enum logic [1:0] {
      APC_IDLE = 2'b01,
      APC_CONV = 2'b10
   } apc_st_t;
   typedef struct packed {
      apc_st_t st;
      logic [7:0] pcfg;
      logic en;
      logic start;
      logic eoc;
      logic chan_en;
      logic [2:0] chan_sel;
      logic [2:0] cks;
      logic len;
      logic [11:0] res;
      logic [6:0] cnt;
      logic [1:0] irq_st;
      logic [1:0] irq_mask;
      logic [31:0] rdata;
      logic err;
   } apc_state_t;
   typedef struct packed {
      logic [6:0] cnt;
   } apc_div_t;
endpackage : apc_pkg

// File: rtl/apc_tick_if.sv
/*
 Interface between the control core and the converter clock divider.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface apc_tick_if;
   logic [2:0] sel;
   logic run;
   logic tick;
   modport core (output sel, output run, input tick);
   modport div (input sel, input run, output tick);
endinterface : apc_tick_if
`default_nettype wire

// File: rtl/apc_clkdiv.sv
/*
 Converter clock divider: one tick per converter clock period.
 Assumes run stays high for a whole conversion.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apc_params.svh"
module apc_clkdiv (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Core side
   apc_tick_if.div tk
);
   import apc_pkg::*;
   apc_div_t r_r;
   apc_div_t r_nxt;
   logic [6:0] lim;

   always_comb begin
      unique case (tk.sel)
         3'h0: lim = `APC_DIV_0;
         3'h1: lim = `APC_DIV_1;
         3'h2: lim = `APC_DIV_2;
         3'h3: lim = `APC_DIV_3;
         3'h4: lim = `APC_DIV_4;
         3'h5: lim = `APC_DIV_5;
         3'h6: lim = `APC_DIV_6;
         default: lim = `APC_DIV_7;
      endcase
      r_nxt = r_r;
      tk.tick = tk.run && (r_r.cnt == lim - 7'd1);
      if (!tk.run || tk.tick) begin
         r_nxt.cnt = 7'h00;
      end else begin
         r_nxt.cnt = r_r.cnt + 7'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end
endmodule : apc_clkdiv
`default_nettype wire

// File: rtl/apc_port_mux.sv
/*
 Shared port routing: one-hot analog switch and digital isolation.
 Assumes pad logic drives the pins from the gated signals.
*/
`timescale 1ns/1ps
`default_nettype none
module apc_port_mux (
   // Control
   input wire logic [7:0] pcfg,
   input wire logic route_on,
   input wire logic [2:0] chan_sel,
   // Pad side
   input wire logic [7:0] pad_in,
   input wire logic [7:0] pullup_req,
   // Outputs
   output logic [7:0] port_din,
   output logic [7:0] pullup_en,
   output logic [7:0] ain_switch
);
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         // At most one switch closed
         assign ain_switch[g] = route_on && (chan_sel == 3'(g));
         // Pure analog pin loses input path and pull-up
         assign port_din[g] = pad_in[g] & ~pcfg[g];
         assign pullup_en[g] = pullup_req[g] & ~pcfg[g];
      end
   endgenerate
endmodule : apc_port_mux
`default_nettype wire

// File: rtl/apc_top.sv
/*
 Converter control block: APB registers, conversion sequencer,
 port configuration and interrupt.
 Assumes an analog core that presents a settled 12-bit code on
 conv_result by the end of a conversion, and pad logic for port pins.
*/
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "apc_params.svh"
module apc_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog core
   input wire logic [11:0] conv_result,
   output logic conv_power,
   output logic conv_active,
   output logic conv_len,
   // Port pins
   input wire logic [7:0] pad_in,
   input wire logic [7:0] pullup_req,
   output logic [7:0] port_din,
   output logic [7:0] pullup_en,
   output logic [7:0] ain_switch,
   // Interrupt
   output logic irq
);
   import apc_pkg::*;

   apc_state_t r_r;
   apc_state_t r_nxt;
   apc_tick_if tk ();
   logic wr;
   logic setup;
   logic [9:0] idx;
   logic hit;
   logic [6:0] total;
   logic [1:0] ev;

   function automatic logic [31:0] rd_word(input apc_state_t s,
                                           input logic [9:0] i);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (i)
         `APC_IDX_PCFG: begin
            w[7:0] = s.pcfg;
         end
         `APC_IDX_MODE: begin
            w[`APC_MODE_EN] = s.en;
            w[`APC_MODE_START] = s.start;
            w[`APC_MODE_EOC] = s.eoc;
            w[`APC_MODE_CHEN] = s.chan_en;
            w[2:0] = s.chan_sel;
         end
         `APC_IDX_RESH: begin
            w[7:0] = s.res[11:4];
         end
         `APC_IDX_RESL: begin
            w[`APC_RESL_CKS2] = s.cks[2];
            w[`APC_RESL_CKS1] = s.cks[1];
            w[`APC_RESL_LEN] = s.len;
            w[`APC_RESL_CKS0] = s.cks[0];
            w[3:0] = s.res[3:0];
         end
         `APC_IDX_IRQS: begin
            w[1:0] = s.irq_st;
         end
         `APC_IDX_IRQM: begin
            w[1:0] = s.irq_mask;
         end
         default: begin
            w = 32'h0000_0000;
         end
      endcase
      return w;
   endfunction : rd_word

   apc_clkdiv u_div (
      .pclk(pclk),
      .presetn(presetn),
      .tk(tk.div)
   );

   apc_port_mux u_mux (
      .pcfg(r_r.pcfg),
      .route_on(r_r.en && r_r.chan_en),
      .chan_sel(r_r.chan_sel),
      .pad_in(pad_in),
      .pullup_req(pullup_req),
      .port_din(port_din),
      .pullup_en(pullup_en),
      .ain_switch(ain_switch)
   );

   assign tk.sel = r_r.cks;
   assign tk.run = (r_r.st == APC_CONV);

   always_comb begin
      r_nxt = r_r;
      ev = 2'h0;
      wr = psel && penable && pwrite;
      setup = psel && !penable;
      idx = paddr[11:2];
      hit = (idx == `APC_IDX_PCFG) || (idx == `APC_IDX_MODE) ||
            (idx == `APC_IDX_RESH) || (idx == `APC_IDX_RESL) ||
            (idx == `APC_IDX_IRQS) || (idx == `APC_IDX_IRQM);
      // Resolution fixes the number of converter clocks
      if (r_r.len) begin
         total = `APC_TICKS12;
      end else begin
         total = `APC_TICKS8;
      end
      // Answer prepared in setup so read data comes from flops
      if (setup) begin
         r_nxt.rdata = pwrite ? 32'h0000_0000 : rd_word(r_r, idx);
         r_nxt.err = !hit;
      end
      // Software writes
      if (wr) begin
         unique case (idx)
            `APC_IDX_PCFG: begin
               r_nxt.pcfg = pwdata[7:0];
            end
            `APC_IDX_MODE: begin
               r_nxt.en = pwdata[`APC_MODE_EN];
               r_nxt.start = pwdata[`APC_MODE_START];
               r_nxt.eoc = pwdata[`APC_MODE_EOC];
               r_nxt.chan_en = pwdata[`APC_MODE_CHEN];
               r_nxt.chan_sel = pwdata[2:0];
            end
            `APC_IDX_RESL: begin
               r_nxt.cks = {pwdata[`APC_RESL_CKS2],
                            pwdata[`APC_RESL_CKS1],
                            pwdata[`APC_RESL_CKS0]};
               r_nxt.len = pwdata[`APC_RESL_LEN];
            end
            `APC_IDX_IRQS: begin
               r_nxt.irq_st = r_r.irq_st & ~pwdata[1:0];
            end
            `APC_IDX_IRQM: begin
               r_nxt.irq_mask = pwdata[1:0];
            end
            default: begin
               r_nxt.err = r_r.err;
            end
         endcase
      end
      // Sequencer; its updates follow the writes so hardware wins
      r_nxt.cnt = r_r.cnt;
      unique case (r_r.st)
         APC_IDLE: begin
            if (r_r.start && r_r.en) begin
               r_nxt.st = APC_CONV;
               r_nxt.cnt = 7'h00;
               r_nxt.eoc = 1'b0;
            end else if (r_r.start) begin
               // Powered-down converter cannot sample
               r_nxt.start = 1'b0;
               ev[`APC_IRQ_REFUSED] = 1'b1;
            end
         end
         APC_CONV: begin
            if (!r_r.en || !r_r.start) begin
               // Aborted run leaves the old result in place
               r_nxt.st = APC_IDLE;
               r_nxt.start = 1'b0;
               r_nxt.cnt = 7'h00;
            end else if (tk.tick) begin
               if (r_r.cnt == total - 7'd1) begin
                  r_nxt.st = APC_IDLE;
                  r_nxt.cnt = 7'h00;
                  r_nxt.eoc = 1'b1;
                  r_nxt.start = 1'b0;
                  ev[`APC_IRQ_DONE] = 1'b1;
                  if (r_r.len) begin
                     r_nxt.res = conv_result;
                  end else begin
                     // Low nibble meaningless in short mode
                     r_nxt.res = {conv_result[11:4], 4'h0};
                  end
               end else begin
                  r_nxt.cnt = r_r.cnt + 7'd1;
               end
            end
         end
      endcase
      // Event set wins over a clear in the same cycle
      r_nxt.irq_st = r_nxt.irq_st | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r.st <= APC_IDLE;
         r_r.pcfg <= `APC_PCFG_RST;
         r_r.en <= 1'b0;
         r_r.start <= 1'b0;
         r_r.eoc <= 1'b0;
         r_r.chan_en <= 1'b0;
         r_r.chan_sel <= `APC_CHSEL_RST;
         r_r.cks <= `APC_CKS_RST;
         r_r.len <= 1'b0;
         r_r.res <= `APC_RES_RST;
         r_r.cnt <= 7'h00;
         r_r.irq_st <= `APC_IRQ_RST;
         r_r.irq_mask <= `APC_IRQ_RST;
         r_r.rdata <= 32'h0000_0000;
         r_r.err <= 1'b0;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Single-cycle access phase
   assign pready = psel && penable;
   assign prdata = r_r.rdata;
   assign pslverr = psel && penable && r_r.err;
   assign conv_power = r_r.en;
   assign conv_active = (r_r.st == APC_CONV);
   assign conv_len = r_r.len;
   assign irq = |(r_r.irq_st & r_r.irq_mask);
endmodule : apc_top
`default_nettype wire

// File: testbench/apc_top_properties.sv
/* Port checker for the converter control block.
 Assumes binding to apc_top and an APB master that holds each request. */
`timescale 1ns/1ps
`default_nettype none
module apc_top_properties (
   // Clock, reset and bus
   input wire logic pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   // Converter and port
   input wire logic conv_power, conv_active, conv_len,
   input wire logic [7:0] pad_in, pullup_req, port_din, pullup_en, ain_switch
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Read data is latched at setup, so it is checked in the access cycle
   sequence rd_s(logic [11:0] a);
      psel && !penable && !pwrite && paddr == a ##1 psel && penable;
   endsequence
   route_onehot_a: assert property ($onehot0(ain_switch))
      else $error("more than one pin routed");
   route_power_a: assert property (|ain_switch |-> conv_power)
      else $error("pin routed while converter off");
   din_gate_a: assert property (
      (pad_in & pullup_req & (port_din ^ pullup_en)) == 8'h0)
      else $error("digital path and pull-up gated apart");
   din_subset_a: assert property (
      ((port_din & ~pad_in) | (pullup_en & ~pullup_req)) == 8'h0)
      else $error("gated path shows a level not on the pad");
   start_enabled_a: assert property ($rose(conv_active) |-> $past(conv_power))
      else $error("conversion started while disabled");
   conv_min_a: assert property ($rose(conv_active) |-> conv_active[*8])
      else $error("conversion ended too soon");
   eoc_busy_a: assert property (conv_active ##0 rd_s(12'h2c4) |-> !prdata[5])
      else $error("completion flag set while busy");
   len_read_a: assert property (rd_s(12'h2cc) |-> prdata[5] == $past(conv_len))
      else $error("resolution bit reads wrong");
endmodule : apc_top_properties
`default_nettype wire

// File: testbench/apc_analog_src.sv
/* Analog sources on the eight shared pins.
 Assumes the bench sets the base level; an unrouted input wanders. */
`timescale 1ns/1ps
`default_nettype none
module apc_analog_src (
   // Clock
   input wire logic pclk,
   // Routing and levels
   input wire logic [7:0] ain_switch,
   input wire logic [11:0] base,
   output logic [11:0] conv_result
);
   logic [11:0] wander_r = 12'h5a5;
   always_ff @(posedge pclk) begin
      wander_r <= ~wander_r;
   end
   always_comb begin
      // Nothing routed: no stable code to latch
      conv_result = wander_r;
      for (int i = 0; i < 8; i++) begin
         if (ain_switch[i]) conv_result = base + 12'(i * 12'h111);
      end
   end
endmodule : apc_analog_src
`default_nettype wire

// File: testbench/tb_top.sv
/* Bench for the converter control block: APB tasks, port and conversion tests.
 Assumes a one-cycle access phase and the partner model on conv_result. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0, base = 12'h0, conv_result, lv;
   logic [31:0] pwdata = 32'h0, prdata, rd, c;
   logic [7:0] pad_in = 8'h0, pullup_req = 8'h0, port_din, pullup_en, ain_switch;
   logic pready, pslverr, conv_power, conv_active, conv_len, irq, err;
   int n_mismatch = 0, checks = 0, n, len, cks, ch;
   apc_top apc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .conv_result, .conv_power, .conv_active, .conv_len,
      .pad_in, .pullup_req, .port_din, .pullup_en, .ain_switch, .irq);
   apc_analog_src apc_analog_src_inst (.pclk, .ain_switch, .base, .conv_result);
   initial begin
      forever #20 pclk = ~pclk;
   end
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k == 20) begin
         n_mismatch++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   function automatic int div_of(int code);
      int t[7] = '{16, 8, 1, 2, 64, 32, 4};
      return t[code];
   endfunction : div_of
   initial begin
      void'($urandom(62755));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h2b8, 32'h0);
      chk("cfg reset", rd, 32'h0);
      // Corner codes first, then random ones
      for (int i = 0; i < 4; i++) begin
         c = (i == 0) ? 32'h0 : (i == 1) ? 32'hff : 32'($urandom_range(255, 0));
         @(posedge pclk);
         pad_in <= 8'($urandom);
         pullup_req <= 8'($urandom);
         apb(1'b1, 12'h2b8, c);
         apb(1'b0, 12'h2b8, 32'h0);
         chk("cfg", rd, c);
         chk("port_din", port_din, pad_in & ~c[7:0]);
         chk("pullup_en", pullup_en, pullup_req & ~c[7:0]);
      end
      $display("port test done");
      apb(1'b1, 12'h304, 32'h3);
      apb(1'b1, 12'h2c4, 32'h80);
      repeat (2500) @(posedge pclk);
      // Code 7 is reserved, so only 0 to 6 are used
      for (cks = 0; cks < 7; cks++) begin
         len = (cks < 2) ? cks : $urandom_range(1, 0);
         ch = $urandom_range(7, 0);
         @(posedge pclk);
         base <= 12'($urandom);
         apb(1'b1, 12'h2b8, 32'h1 << ch);
         apb(1'b1, 12'h2cc, {cks[2:1], len[0], cks[0], 4'h0});
         apb(1'b1, 12'h2c4, 32'h90 | ch);
         chk("route", ain_switch, 32'h1 << ch);
         chk("power on", conv_power, 1'b1);
         apb(1'b1, 12'h2c4, 32'hd0 | ch);
         n = 0;
         do begin
            @(posedge pclk);
            #1;
            n++;
         end while (conv_active && n < 5000);
         if (n == 5000) begin
            n_mismatch++;
            final_report();
         end
         c = 1 + (len ? 64 : 48) * div_of(cks);
         chk("conv time", n >= c && n <= c + 1, 1'b1);
         lv = base + 12'(ch * 12'h111);
         apb(1'b0, 12'h2c4, 32'h0);
         chk("mode done", rd, 32'hb0 | ch);
         apb(1'b0, 12'h2c8, 32'h0);
         chk("res high", rd, lv[11:4]);
         apb(1'b0, 12'h2cc, 32'h0);
         chk("res low", rd[3:0], len ? lv[3:0] : 4'h0);
         chk("len bit", conv_len, len[0]);
         chk("irq done", irq, 1'b1);
         apb(1'b1, 12'h300, 32'h1);
         chk("irq clear", irq, 1'b0);
      end
      $display("conversion test done");
      apb(1'b1, 12'h2c4, 32'hd0);
      repeat (50) @(posedge pclk);
      apb(1'b0, 12'h2c4, 32'h0);
      chk("busy eoc", rd[5], 1'b0);
      apb(1'b1, 12'h2c4, 32'h90);
      @(posedge pclk);
      #1;
      chk("abort", conv_active, 1'b0);
      apb(1'b0, 12'h2c8, 32'h0);
      chk("held", rd, lv[11:4]);
      apb(1'b1, 12'h304, 32'h1);
      apb(1'b1, 12'h2c4, 32'h40);
      apb(1'b0, 12'h2c4, 32'h0);
      chk("refused mode", rd, 32'h0);
      chk("power off", conv_power, 1'b0);
      chk("masked", irq, 1'b0);
      apb(1'b0, 12'h300, 32'h0);
      chk("refused flag", rd, 32'h2);
      apb(1'b1, 12'h304, 32'h2);
      chk("irq refused", irq, 1'b1);
      apb(1'b1, 12'h300, 32'h2);
      chk("irq cleared", irq, 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("abort and interrupt test done");
      final_report();
   end
endmodule : tb_top
bind apc_top apc_top_properties apc_top_properties_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .conv_power, .conv_active, .conv_len, .pad_in, .pullup_req,
   .port_din, .pullup_en, .ain_switch);
`default_nettype wire
